// ---- shcl_pkg.sv ----
package shcl_pkg;

  // Link byte codes
  localparam logic [7:0] ASCII_ESC   = 8'h1b;
  localparam logic [7:0] ASCII_CR    = 8'h0d;
  localparam logic [7:0] ASCII_COMMA = 8'h2c;
  localparam logic [7:0] ASCII_QUOTE = 8'h22;
  localparam logic [7:0] ASCII_ZERO  = 8'h30;
  localparam logic [7:0] ASCII_NINE  = 8'h39;
  localparam logic [7:0] ASCII_UA    = 8'h41;
  localparam logic [7:0] ASCII_UF    = 8'h46;
  localparam logic [7:0] ASCII_LA    = 8'h61;
  localparam logic [7:0] ASCII_LF    = 8'h66;
  localparam logic [7:0] HEX_ALPHA   = 8'h0a;

  // Command codes (byte after the escape)
  localparam logic [7:0] CMD_SHOW_SCREEN = 8'h30;
  localparam logic [7:0] CMD_ASK_SCREEN  = 8'h58;
  localparam logic [7:0] CMD_ASK_LAMPS   = 8'h52;
  localparam logic [7:0] CMD_ASK_STATUS  = 8'h5a;
  localparam logic [7:0] CMD_BUZZER      = 8'h54;
  localparam logic [7:0] CMD_DISPLAY     = 8'h50;
  localparam logic [7:0] CMD_TOUCH_OFF   = 8'h55;
  localparam logic [7:0] CMD_TOUCH_ON    = 8'h56;
  localparam logic [7:0] CMD_CLEAR       = 8'h26;
  localparam logic [7:0] CMD_CURSOR      = 8'h2b;
  localparam logic [7:0] RSP_SCREEN      = 8'h59;
  localparam logic [7:0] RSP_LAMPS       = 8'h53;
  localparam logic [7:0] RSP_STATUS      = 8'h5b;

  // Argument counts in hex characters, and field widths in bits
  localparam logic [3:0] NARG_NONE   = 4'h0;
  localparam logic [3:0] NARG_ONE    = 4'h1;
  localparam logic [3:0] NARG_SCREEN = 4'h4;
  localparam logic [3:0] NARG_COORD  = 4'h6;
  localparam int         NIB_W       = 4;
  localparam int         ARG_W       = 32;
  localparam int         COORD_W     = 12;

  // Screen area in dots
  localparam logic [11:0] SCREEN_W = 12'h280;
  localparam logic [11:0] SCREEN_H = 12'h190;

  // Inter-byte gap limit
  localparam int unsigned TIMEOUT_S   = 5;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;

  // Reply frame: escape, code, four hex digits, carriage return
  localparam logic [2:0] TX_IDX_ESC  = 3'h0;
  localparam logic [2:0] TX_IDX_CODE = 3'h1;
  localparam logic [2:0] TX_IDX_LAST = 3'h6;
  localparam int         TX_BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    KIND_OPER = 3'b001,
    KIND_ENQ  = 3'b010,
    KIND_TERM = 3'b100
  } shcl_kind_t;

  typedef struct packed {
    logic       known;
    logic [3:0] nargs;
    shcl_kind_t kind;
    logic [7:0] rcode;
  } shcl_info_t;

  typedef struct packed {
    logic [7:0]  code;
    shcl_kind_t  kind;
    logic [31:0] args;
  } shcl_exec_t;

  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] data;
  } shcl_reply_t;

  function automatic shcl_info_t shcl_lookup(input logic [7:0] c);
    shcl_info_t r;
    r = '{known: 1'b1, nargs: NARG_NONE, kind: KIND_OPER, rcode: '0};
    case (c)
      CMD_SHOW_SCREEN: r.nargs = NARG_SCREEN;
      CMD_ASK_SCREEN:  begin r.kind = KIND_ENQ; r.rcode = RSP_SCREEN; end
      CMD_ASK_LAMPS:   begin r.kind = KIND_ENQ; r.rcode = RSP_LAMPS; end
      CMD_ASK_STATUS:  begin r.kind = KIND_ENQ; r.rcode = RSP_STATUS; end
      CMD_BUZZER:      r.nargs = NARG_ONE;
      CMD_DISPLAY:     r.nargs = NARG_ONE;
      CMD_TOUCH_OFF:   r.nargs = NARG_NONE;
      CMD_TOUCH_ON:    r.nargs = NARG_NONE;
      CMD_CLEAR:       r.kind = KIND_TERM;
      CMD_CURSOR:      begin r.kind = KIND_TERM; r.nargs = NARG_COORD; end
      default:         r.known = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] shcl_from_ascii(input logic [7:0] c);
    logic [7:0] v;
    v = '0;
    if (c >= ASCII_ZERO && c <= ASCII_NINE) begin
      v = c - ASCII_ZERO;
    end else if (c >= ASCII_UA && c <= ASCII_UF) begin
      v = c - ASCII_UA + HEX_ALPHA;
    end else if (c >= ASCII_LA && c <= ASCII_LF) begin
      v = c - ASCII_LA + HEX_ALPHA;
    end
    return v[3:0];
  endfunction

  function automatic logic [7:0] shcl_to_ascii(input logic [3:0] n);
    logic [7:0] w;
    w = {4'h0, n};
    return (w < HEX_ALPHA) ? (ASCII_ZERO + w) : (ASCII_UA + w - HEX_ALPHA);
  endfunction

endpackage

// ---- shcl_tx_buffer.sv ----
`timescale 1ns/10ps
`default_nettype none
module shcl_tx_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready_o  = (cnt_q != CNT_FULL);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
      wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + PW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + PW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_q <= '{default: '0};
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ---- shcl_command_link.sv ----
// Functional notes
// - Terminal commands are executed without any reply to the host.
// - Bytes beyond a command's defined length are discarded.
// - A command cut short ends in a timeout error, never executed.
// - A gap over 5 seconds inside a command raises a timeout error.
// - Bytes arriving while a command is still executing raise buffer overflow.
// - Buzzer command acts only while the buzzer switch is on.
// - Terminal command with any coordinate off screen is dropped entirely.
// - Auto-reset switch on suppresses the on-screen error message.
// - Sent commands carry no comma or double quote; each ends in a line end. Notification code bytes are sent unchecked.
`timescale 1ns/10ps
`default_nettype none
module shcl_command_link
  import shcl_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        sw_buzzer_i,
  input  wire logic        sw_auto_reset_i,
  output logic             exec_valid_o,
  output shcl_exec_t       exec_o,
  input  wire logic        exec_ready_i,
  input  wire logic        resp_valid_i,
  input  wire logic [15:0] resp_data_i,
  output logic             resp_ready_o,
  input  wire logic        note_valid_i,
  input  wire shcl_reply_t note_i,
  output logic             note_ready_o,
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  input  wire logic        tx_ready_i,
  output logic             err_timeout_o,
  output logic             err_overflow_o,
  output logic             err_msg_o
);
  localparam logic [31:0] TMR_LAST = 32'(TIMEOUT_CYCLES - 1);
  // Slot of the least significant hex digit, just before the line end
  localparam logic [2:0]  TX_IDX_LSD = TX_IDX_LAST - 3'h1;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_CODE = 4'b0010,
    RX_ARGS = 4'b0100,
    RX_EXEC = 4'b1000
  } shcl_rx_state_t;

  // Memory switches come from pins: two-stage synchroniser
  logic [1:0] sw_meta_q, sw_sync_q;
  logic       sw_buz, sw_auto;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_meta_q <= '0;
      sw_sync_q <= '0;
    end else begin
      sw_meta_q <= {sw_auto_reset_i, sw_buzzer_i};
      sw_sync_q <= sw_meta_q;
    end
  end
  assign sw_buz  = sw_sync_q[0];
  assign sw_auto = sw_sync_q[1];

  // Receive side
  shcl_rx_state_t state_q, state_d;
  shcl_info_t     info_q, info_d, look;
  logic [7:0]     code_q, code_d;
  logic [3:0]     left_q, left_d;
  logic [31:0]    arg_q, arg_d, tmr_q, tmr_d;
  logic           exec_vq, exec_vd;
  shcl_exec_t     exec_q, exec_d;
  logic           pend_q, pend_d;
  logic [7:0]     pcode_q, pcode_d;
  logic           to_q, to_d, ov_q, ov_d, msg_q, msg_d;
  logic           in_cmd, timeout_hit, done, keep, accepted;
  logic [3:0]     nib;
  logic [31:0]    arg_n;
  logic [11:0]    crd_x, crd_y;
  logic           take_resp, take_note;

  assign look        = shcl_lookup(rx_data_i);
  assign nib         = shcl_from_ascii(rx_data_i);
  assign arg_n       = {arg_q[ARG_W-NIB_W-1:0], nib};
  assign in_cmd      = (state_q == RX_CODE) || (state_q == RX_ARGS);
  assign timeout_hit = in_cmd && !rx_valid_i && (tmr_q == TMR_LAST);
  assign accepted    = exec_vq && exec_ready_i;
  assign crd_x       = arg_n[2*COORD_W-1:COORD_W];
  assign crd_y       = arg_n[COORD_W-1:0];

  always_comb begin
    state_d = state_q;
    info_d  = info_q;
    code_d  = code_q;
    left_d  = left_q;
    arg_d   = arg_q;
    exec_vd = exec_vq;
    exec_d  = exec_q;
    to_d    = 1'b0;
    ov_d    = 1'b0;
    done    = 1'b0;
    keep    = 1'b1;
    tmr_d   = (in_cmd && !rx_valid_i) ? tmr_q + 32'(1) : '0;
    case (state_q)
      RX_IDLE: begin
        // Anything but an escape here is surplus of an earlier command
        if (rx_valid_i && rx_data_i == ASCII_ESC) begin
          state_d = RX_CODE;
        end
      end
      RX_CODE: begin
        if (rx_valid_i) begin
          info_d = look;
          code_d = rx_data_i;
          arg_d  = '0;
          left_d = look.nargs;
          if (!look.known) begin
            state_d = RX_IDLE;
          end else if (look.nargs == NARG_NONE) begin
            done = 1'b1;
          end else begin
            state_d = RX_ARGS;
          end
        end else if (timeout_hit) begin
          state_d = RX_IDLE;
          to_d    = 1'b1;
        end
      end
      RX_ARGS: begin
        if (rx_valid_i) begin
          arg_d  = arg_n;
          left_d = left_q - 4'h1;
          done   = (left_q == NARG_ONE);
        end else if (timeout_hit) begin
          state_d = RX_IDLE;
          to_d    = 1'b1;
        end
      end
      RX_EXEC: begin
        if (rx_valid_i) begin
          ov_d = 1'b1;
        end
        if (accepted) begin
          state_d = RX_IDLE;
          exec_vd = 1'b0;
        end
      end
      default: state_d = RX_IDLE;
    endcase
    if (done) begin
      if (code_d == CMD_BUZZER && !sw_buz) begin
        keep = 1'b0;
      end
      if (code_d == CMD_CURSOR && (state_q == RX_ARGS) && (crd_x >= SCREEN_W || crd_y >= SCREEN_H)) begin
        keep = 1'b0;
      end
      if (info_d.kind == KIND_ENQ && pend_q) begin
        keep = 1'b0;
      end
      state_d = keep ? RX_EXEC : RX_IDLE;
      exec_vd = keep;
      exec_d  = '{code: code_d, kind: info_d.kind, args: arg_d};
    end
  end

  // Pending enquiry answer; a new enquiry wins over the clear
  always_comb begin
    pend_d  = pend_q;
    pcode_d = pcode_q;
    if (take_resp) begin
      pend_d = 1'b0;
    end
    if (accepted && exec_q.kind == KIND_ENQ) begin
      pend_d  = 1'b1;
      pcode_d = info_q.rcode;
    end
    msg_d = (to_d || ov_d) && !sw_auto;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= RX_IDLE;
      info_q  <= '{known: 1'b0, nargs: NARG_NONE, kind: KIND_OPER, rcode: '0};
      code_q  <= '0;
      left_q  <= '0;
      arg_q   <= '0;
      tmr_q   <= '0;
      exec_vq <= 1'b0;
      exec_q  <= '{code: '0, kind: KIND_OPER, args: '0};
      pend_q  <= 1'b0;
      pcode_q <= '0;
      to_q    <= 1'b0;
      ov_q    <= 1'b0;
      msg_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      info_q  <= info_d;
      code_q  <= code_d;
      left_q  <= left_d;
      arg_q   <= arg_d;
      tmr_q   <= tmr_d;
      exec_vq <= exec_vd;
      exec_q  <= exec_d;
      pend_q  <= pend_d;
      pcode_q <= pcode_d;
      to_q    <= to_d;
      ov_q    <= ov_d;
      msg_q   <= msg_d;
    end
  end

  assign exec_valid_o   = exec_vq;
  assign exec_o         = exec_q;
  assign err_timeout_o  = to_q;
  assign err_overflow_o = ov_q;
  assign err_msg_o      = msg_q;

  // Transmit side: frames a reply or notification into the buffer
  logic        tx_busy_q, tx_busy_d;
  logic [2:0]  tx_idx_q, tx_idx_d;
  shcl_reply_t tx_rep_q, tx_rep_d;
  logic [7:0]  tx_byte;
  logic        buf_ready;

  assign resp_ready_o = !tx_busy_q && pend_q;
  assign note_ready_o = !tx_busy_q && !(pend_q && resp_valid_i);
  assign take_resp    = resp_ready_o && resp_valid_i;
  assign take_note    = note_ready_o && note_valid_i;

  always_comb begin
    case (tx_idx_q)
      TX_IDX_ESC:  tx_byte = ASCII_ESC;
      TX_IDX_CODE: tx_byte = tx_rep_q.code;
      TX_IDX_LAST: tx_byte = ASCII_CR;
      default:     tx_byte = shcl_to_ascii(4'(tx_rep_q.data >> (NIB_W * (TX_IDX_LSD - tx_idx_q))));
    endcase
  end

  always_comb begin
    tx_busy_d = tx_busy_q;
    tx_idx_d  = tx_idx_q;
    tx_rep_d  = tx_rep_q;
    if (!tx_busy_q) begin
      if (take_resp) begin
        tx_busy_d = 1'b1;
        tx_idx_d  = TX_IDX_ESC;
        tx_rep_d  = '{code: pcode_q, data: resp_data_i};
      end else if (take_note) begin
        tx_busy_d = 1'b1;
        tx_idx_d  = TX_IDX_ESC;
        tx_rep_d  = note_i;
      end
    end else if (buf_ready) begin
      tx_idx_d  = tx_idx_q + 3'h1;
      tx_busy_d = (tx_idx_q != TX_IDX_LAST);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_busy_q <= 1'b0;
      tx_idx_q  <= TX_IDX_ESC;
      tx_rep_q  <= '0;
    end else begin
      tx_busy_q <= tx_busy_d;
      tx_idx_q  <= tx_idx_d;
      tx_rep_q  <= tx_rep_d;
    end
  end

  shcl_tx_buffer #(
    .WIDTH (8),
    .DEPTH (TX_BUF_DEPTH)
  ) u_tx_buffer (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (tx_busy_q),
    .in_data_i   (tx_byte),
    .in_ready_o  (buf_ready),
    .out_valid_o (tx_valid_o),
    .out_data_o  (tx_data_o),
    .out_ready_i (tx_ready_i)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_frame_start;
    tx_busy_q && tx_idx_q == TX_IDX_ESC;
  endsequence
  sequence s_enq_accept;
    accepted && exec_q.kind == KIND_ENQ;
  endsequence

  a_gap_timeout: assert property (timeout_hit |=> err_timeout_o && state_q == RX_IDLE)
    else $error("gap limit did not raise timeout");
  a_short_no_exec: assert property (err_timeout_o |-> !exec_valid_o && !$past(done))
    else $error("partial command executed");
  a_surplus_drop: assert property (state_q == RX_IDLE && rx_valid_i && rx_data_i != ASCII_ESC
                                   |=> state_q == RX_IDLE)
    else $error("surplus byte started a command");
  a_overflow_flag: assert property (state_q == RX_EXEC && rx_valid_i |=> err_overflow_o)
    else $error("lost byte not reported");
  a_buzzer_gate: assert property ($rose(exec_valid_o) && exec_o.code == CMD_BUZZER |-> $past(sw_buz))
    else $error("buzzer command passed with switch off");
  a_coord_range: assert property ($rose(exec_valid_o) && exec_o.code == CMD_CURSOR
                                  |-> exec_o.args[2*COORD_W-1:COORD_W] < SCREEN_W
                                      && exec_o.args[COORD_W-1:0] < SCREEN_H)
    else $error("off-screen coordinate executed");
  a_msg_suppress: assert property ((err_timeout_o || err_overflow_o) |-> err_msg_o == !$past(sw_auto))
    else $error("error message gating wrong");
  a_term_silent: assert property (accepted && exec_q.kind == KIND_TERM |=> !$rose(pend_q))
    else $error("terminal command armed a reply");
  a_enq_reply: assert property (s_enq_accept |=> pend_q ##0 resp_ready_o || tx_busy_q)
    else $error("enquiry not armed for reply");
  a_note_frame: assert property (take_note && !take_resp |=> s_frame_start ##0 tx_rep_q == $past(note_i))
    else $error("notification not framed");
  a_no_delim: assert property (tx_valid_o |-> tx_data_o != ASCII_COMMA && tx_data_o != ASCII_QUOTE)
    else $error("delimiter in sent command");
endmodule
`default_nettype wire

// ---- shcl_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module shcl_host_model (
  input  wire logic       ref_clk_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] got [$];
  logic       slow;
  int         gap;
  int         ph;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b1;
    slow       = 1'b0;
    gap        = 3;
    ph         = 0;
  end
  // Slow mode takes a byte only every third cycle
  always @(negedge ref_clk_i) begin
    ph <= ph + 1;
    tx_ready_o <= !slow || (ph % 3 == 0);
  end
  // Each byte is queued on its own, whenever it is valid and ready
  always @(posedge ref_clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
  end
  task automatic send(input logic [7:0] b);
    @(negedge ref_clk_i);
    rx_valid_o = 1'b1;
    rx_data_o  = b;
    @(negedge ref_clk_i);
    rx_valid_o = 1'b0;
    rx_data_o  = ~b;
    repeat (gap) @(negedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import shcl_pkg::*;
  localparam int unsigned TO = 20;
  logic        ref_clk_i;
  logic        rst_i;
  logic        sw_buz;
  logic        sw_auto;
  logic        exec_valid;
  logic        exec_ready;
  shcl_exec_t  exec_q;
  shcl_exec_t  last;
  logic        resp_valid;
  logic [15:0] resp_data;
  logic        resp_ready;
  logic        note_valid;
  shcl_reply_t note;
  logic        note_ready;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic        err_to;
  logic        err_ov;
  logic        err_msg;
  int          mismatches;
  int          checks;
  int          n_exec;
  int          n_to;
  int          n_ov;
  int          n_msg;

  shcl_command_link #(.TIMEOUT_CYCLES(TO)) u_shcl_command_link (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .sw_buzzer_i(sw_buz), .sw_auto_reset_i(sw_auto), .exec_valid_o(exec_valid),
    .exec_o(exec_q), .exec_ready_i(exec_ready), .resp_valid_i(resp_valid),
    .resp_data_i(resp_data), .resp_ready_o(resp_ready), .note_valid_i(note_valid),
    .note_i(note), .note_ready_o(note_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready), .err_timeout_o(err_to), .err_overflow_o(err_ov), .err_msg_o(err_msg));

  shcl_host_model u_shcl_host_model (
    .ref_clk_i(ref_clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (exec_valid && exec_ready) begin
      n_exec++;
      last = exec_q;
    end
    if (err_to) n_to++;
    if (err_ov) n_ov++;
    if (err_msg) n_msg++;
  end

  task automatic results();
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #300000;
    mismatches++;
    results();
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction

  task automatic cmd(input logic [7:0] c, input logic [47:0] a, input int n);
    u_shcl_host_model.send(ASCII_ESC);
    u_shcl_host_model.send(c);
    for (int i = 0; i < n; i++) u_shcl_host_model.send(a[8*(n-1-i)+:8]);
    repeat (4) @(negedge ref_clk_i);
  endtask

  task automatic ex(input int n0, input logic [7:0] c, input shcl_kind_t k, input logic [31:0] a);
    chk(n_exec - n0, 1);
    chk({last.code, last.kind, last.args}, {c, k, a});
  endtask

  task automatic offer(input logic n);
    int k;
    k = 0;
    @(negedge ref_clk_i);
    if (n) note_valid = 1'b1;
    else resp_valid = 1'b1;
    while ((n ? note_ready : resp_ready) !== 1'b1 && k < 50) begin
      @(negedge ref_clk_i);
      k++;
    end
    chk(k < 50, 1);
    @(negedge ref_clk_i);
    note_valid = 1'b0;
    resp_valid = 1'b0;
  endtask

  task automatic frame(input logic [7:0] c, input logic [15:0] d);
    logic [7:0] e [7];
    int         k;
    e = '{ASCII_ESC, c, hx(d[15:12]), hx(d[11:8]), hx(d[7:4]), hx(d[3:0]), ASCII_CR};
    k = 0;
    while (u_shcl_host_model.got.size() < 7 && k < 300) begin
      @(negedge ref_clk_i);
      k++;
    end
    repeat (10) @(negedge ref_clk_i);
    chk(u_shcl_host_model.got.size(), 7);
    for (int i = 0; i < 7; i++) chk(u_shcl_host_model.got[i], e[i]);
    u_shcl_host_model.got.delete();
  endtask

  task automatic t_enquiry();
    logic [7:0] q [3];
    logic [7:0] r [3];
    int         n0;
    q = '{CMD_ASK_SCREEN, CMD_ASK_LAMPS, CMD_ASK_STATUS};
    r = '{RSP_SCREEN, RSP_LAMPS, RSP_STATUS};
    u_shcl_host_model.slow = 1'b1;
    for (int i = 0; i < 3; i++) begin
      n0 = n_exec;
      cmd(q[i], 48'h0, 0);
      ex(n0, q[i], KIND_ENQ, 32'h0);
      resp_data = 16'h03e8 + 16'(i * 16'h1111);
      offer(1'b0);
      frame(r[i], 16'h03e8 + 16'(i * 16'h1111));
    end
    u_shcl_host_model.slow = 1'b0;
  endtask

  task automatic t_terminal();
    int n0;
    n0 = n_exec;
    cmd(CMD_CLEAR, 48'h0, 0);
    ex(n0, CMD_CLEAR, KIND_TERM, 32'h0);
    n0 = n_exec;
    cmd(CMD_CURSOR, 48'h323746313846, 6);
    ex(n0, CMD_CURSOR, KIND_TERM, 32'h0027f18f);
    n0 = n_exec;
    cmd(CMD_CURSOR, 48'h323830303030, 6);
    cmd(CMD_CURSOR, 48'h303030313930, 6);
    chk(n_exec - n0, 0);
    repeat (20) @(negedge ref_clk_i);
    chk(u_shcl_host_model.got.size(), 0);
  endtask

  task automatic t_surplus();
    int n0;
    int o0;
    n0 = n_exec;
    o0 = n_ov;
    cmd(CMD_DISPLAY, 48'h3132, 2);
    ex(n0, CMD_DISPLAY, KIND_OPER, 32'h1);
    chk(n_ov - o0, 0);
  endtask

  task automatic t_timeout();
    int n0;
    int t0;
    int m0;
    n0 = n_exec;
    t0 = n_to;
    m0 = n_msg;
    cmd(CMD_BUZZER, 48'h0, 0);
    repeat (TO + 10) @(negedge ref_clk_i);
    chk(n_exec - n0, 0);
    chk(n_to - t0, 1);
    chk(n_msg - m0, 1);
    u_shcl_host_model.gap = TO - 3;
    cmd(CMD_DISPLAY, 48'h31, 1);
    chk(n_to - t0, 1);
    ex(n0, CMD_DISPLAY, KIND_OPER, 32'h1);
    u_shcl_host_model.gap = TO + 2;
    sw_auto = 1'b1;
    cmd(CMD_DISPLAY, 48'h31, 1);
    repeat (TO) @(negedge ref_clk_i);
    chk(n_exec - n0, 1);
    chk(n_to - t0, 2);
    chk(n_msg - m0, 1);
    u_shcl_host_model.gap = 3;
    sw_auto = 1'b0;
  endtask

  task automatic t_overflow();
    int n0;
    int o0;
    n0 = n_exec;
    o0 = n_ov;
    exec_ready = 1'b0;
    cmd(CMD_TOUCH_ON, 48'h0, 0);
    u_shcl_host_model.send(8'h41);
    repeat (3) @(negedge ref_clk_i);
    chk({n_ov - o0, exec_valid}, {32'd1, 1'b1});
    exec_ready = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    ex(n0, CMD_TOUCH_ON, KIND_OPER, 32'h0);
  endtask

  task automatic t_buzzer();
    int n0;
    n0 = n_exec;
    cmd(CMD_BUZZER, 48'h31, 1);
    chk(n_exec - n0, 0);
    sw_buz = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    cmd(CMD_BUZZER, 48'h31, 1);
    ex(n0, CMD_BUZZER, KIND_OPER, 32'h1);
  endtask

  task automatic t_note();
    u_shcl_host_model.slow = 1'b1;
    note = '{code: 8'h48, data: 16'h0a5c};
    offer(1'b1);
    frame(8'h48, 16'h0a5c);
    u_shcl_host_model.slow = 1'b0;
  endtask

  initial begin
    rst_i      = 1'b1;
    sw_buz     = 1'b0;
    sw_auto    = 1'b0;
    exec_ready = 1'b1;
    resp_valid = 1'b0;
    resp_data  = 16'h0000;
    note_valid = 1'b0;
    note       = '0;
    mismatches = 0;
    checks     = 0;
    n_exec     = 0;
    n_to       = 0;
    n_ov       = 0;
    n_msg      = 0;
    repeat (5) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    t_enquiry();
    t_terminal();
    t_surplus();
    t_timeout();
    t_overflow();
    t_buzzer();
    t_note();
    results();
  end
endmodule
`default_nettype wire
